// >>> design/sipc_codec.sv
// AXI4-Lite register file, baud generator and infrared pulse codec
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "sipc_map.svh"
// Summary of operation
// - Baud divisor is 16 bits over two byte registers, high byte is MSBs
// - Debug-run clear: block freezes while CPU halted and ignores events
// - Debug-run set: block keeps running while CPU halted
// - Event enable bit selects event channel as infrared receiver source
// - With event input selected the receive pin is ignored
// - Pulse length and filter settings act only in infrared mode
// - Transmit setting zero gives pulses of 3/16 baud period
// - Settings 1 to 254 give pulses of that many system clocks
// - Each transmit pulse starts on a rising baud clock edge
// - Setting 255 bypasses coding; tx passes unchanged, rx passes uninverted but still through the receive filter
// - Receive filter setting zero bypasses the filter
// - Nonzero setting x needs x+1 consecutive equal samples
module sipc_codec
    import sipc_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  cpuHalted,
    input  wire logic                  txData,
    output logic                       rxData,
    input  wire logic                  rxPin,
    input  wire logic                  eventIn,
    output logic                       txPin,
    output logic                       baudTick
);
    initial begin
        if (ADDR_WIDTH < 6 || ADDR_WIDTH > 32) begin
            $error("sipc_codec: ADDR_WIDTH out of range");
        end
    end

    // Registers
    logic [15:0] baudDiv_reg;
    logic        runHalted_reg;
    logic        eventEn_reg;
    logic        irMode_reg;
    logic [7:0]  txPulseLen_reg;
    logic [6:0]  rxFilterLen_reg;

    // Pin synchronisers
    logic [1:0] rxSync_reg;
    logic [1:0] evSync_reg;
    logic [1:0] haltSync_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxSync_reg   <= 2'b11;
            evSync_reg   <= 2'b11;
            haltSync_reg <= 2'b00;
        end else begin
            rxSync_reg   <= {rxSync_reg[0], rxPin};
            evSync_reg   <= {evSync_reg[0], eventIn};
            haltSync_reg <= {haltSync_reg[0], cpuHalted};
        end
    end

    logic runEn;
    assign runEn = runHalted_reg | ~haltSync_reg[1];

    // AXI4-Lite write path: address and data taken in either order
    logic                  awHeld_reg;
    logic                  wHeld_reg;
    logic [ADDR_WIDTH-1:0] awAddr_reg;
    logic [31:0]           wData_reg;
    logic [3:0]            wStrb_reg;
    logic                  bValid_reg;
    logic [1:0]            bResp_reg;

    assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
    assign s_axi_wready  = ~wHeld_reg & ~bValid_reg;

    logic                  awTake;
    logic                  wTake;
    logic                  doWrite;
    logic [ADDR_WIDTH-1:0] wrAddr;
    logic [31:0]           wrData;
    logic [3:0]            wrStrb;
    logic [ADDR_WIDTH-3:0] wrIdx;

    assign awTake  = s_axi_awvalid & s_axi_awready;
    assign wTake   = s_axi_wvalid & s_axi_wready;
    assign wrAddr  = awHeld_reg ? awAddr_reg : s_axi_awaddr;
    assign wrData  = wHeld_reg ? wData_reg : s_axi_wdata;
    assign wrStrb  = wHeld_reg ? wStrb_reg : s_axi_wstrb;
    assign doWrite = (awHeld_reg | awTake) & (wHeld_reg | wTake);
    assign wrIdx   = wrAddr[ADDR_WIDTH-1:2];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            awAddr_reg <= '0;
            wData_reg  <= 32'h00000000;
            wStrb_reg  <= 4'h0;
        end else if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
        end else begin
            if (awTake) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (wTake) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
        end
    end

    logic wrHit;
    always_comb begin
        if (wrIdx == `SIPC_IDX_BAUD_LOW) begin
            wrHit = 1'b1;
        end else if (wrIdx == `SIPC_IDX_BAUD_HIGH) begin
            wrHit = 1'b1;
        end else if (wrIdx == `SIPC_IDX_MODE) begin
            wrHit = 1'b1;
        end else if (wrIdx == `SIPC_IDX_DEBUG_RUN) begin
            wrHit = 1'b1;
        end else if (wrIdx == `SIPC_IDX_EVENT_CTRL) begin
            wrHit = 1'b1;
        end else if (wrIdx == `SIPC_IDX_TX_PULSE) begin
            wrHit = 1'b1;
        end else if (wrIdx == `SIPC_IDX_RX_FILTER) begin
            wrHit = 1'b1;
        end else begin
            wrHit = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            baudDiv_reg     <= `SIPC_RST_BAUD;
            runHalted_reg   <= 1'b0;
            eventEn_reg     <= 1'b0;
            irMode_reg      <= 1'b0;
            txPulseLen_reg  <= `SIPC_RST_BYTE;
            rxFilterLen_reg <= 7'h00;
        end else if (doWrite && wrStrb[0]) begin
            if (wrIdx == `SIPC_IDX_BAUD_LOW) begin
                baudDiv_reg[7:0] <= wrData[7:0];
            end else if (wrIdx == `SIPC_IDX_BAUD_HIGH) begin
                baudDiv_reg[15:8] <= wrData[7:0];
            end else if (wrIdx == `SIPC_IDX_MODE) begin
                irMode_reg <= wrData[`SIPC_BIT_IR_MODE];
            end else if (wrIdx == `SIPC_IDX_DEBUG_RUN) begin
                runHalted_reg <= wrData[`SIPC_BIT_RUN_HALTED];
            end else if (wrIdx == `SIPC_IDX_EVENT_CTRL) begin
                eventEn_reg <= wrData[`SIPC_BIT_EVENT_ENABLE];
            end else if (wrIdx == `SIPC_IDX_TX_PULSE) begin
                txPulseLen_reg <= wrData[7:0];
            end else if (wrIdx == `SIPC_IDX_RX_FILTER) begin
                rxFilterLen_reg <= wrData[6:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bValid_reg <= 1'b0;
            bResp_reg  <= SIPC_OKAY;
        end else if (doWrite) begin
            bValid_reg <= 1'b1;
            bResp_reg  <= wrHit ? SIPC_OKAY : SIPC_SLVERR;
        end else if (s_axi_bready) begin
            bValid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp  = bResp_reg;

    // Baud generator: one tick per bit every 16 divisor periods, divisor counted in system clocks
    logic [15:0] baudCnt_reg;
    logic        baudTick_reg;
    logic [3:0]  sixteenth_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            baudCnt_reg   <= 16'h0000;
            baudTick_reg  <= 1'b0;
            sixteenth_reg <= 4'h0;
        end else if (runEn) begin
            baudTick_reg <= 1'b0;
            if (baudCnt_reg >= baudDiv_reg) begin
                baudCnt_reg   <= 16'h0000;
                sixteenth_reg <= sixteenth_reg + 4'h1;
                baudTick_reg  <= (sixteenth_reg == 4'hF);
            end else begin
                baudCnt_reg <= baudCnt_reg + 16'h0001;
            end
        end else begin
            baudTick_reg <= 1'b0;
        end
    end

    assign baudTick = baudTick_reg;

    // Transmit pulse shaping: a low data bit becomes a short high pulse
    sipc_tx_state_t txState_reg;
    logic [15:0]    pulseCnt_reg;
    logic           txOut_reg;
    logic           txBypass;
    logic [15:0]    pulseLen316;
    logic [15:0]    pulseLen;

    assign txBypass    = ~irMode_reg | (txPulseLen_reg == `SIPC_TX_PULSE_BYPASS);
    assign pulseLen316 = 16'(`SIPC_PULSE_SIXTEENTHS) * (baudDiv_reg + 16'h0001);
    assign pulseLen    = (txPulseLen_reg == `SIPC_TX_PULSE_316) ? pulseLen316
                                                                : {8'h00, txPulseLen_reg};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            txState_reg  <= SIPC_TX_IDLE;
            pulseCnt_reg <= 16'h0000;
            txOut_reg    <= 1'b1;
        end else if (!runEn) begin
            txState_reg <= txState_reg;
        end else if (txBypass) begin
            txState_reg <= SIPC_TX_IDLE;
            txOut_reg   <= txData;
        end else begin
            case (txState_reg)
                SIPC_TX_IDLE: begin
                    txOut_reg <= 1'b0;
                    if (baudTick_reg && !txData) begin
                        txState_reg  <= SIPC_TX_PULSE;
                        txOut_reg    <= 1'b1;
                        pulseCnt_reg <= 16'h0001;
                    end
                end
                SIPC_TX_PULSE: begin
                    if (pulseCnt_reg >= pulseLen) begin
                        txState_reg <= SIPC_TX_GAP;
                        txOut_reg   <= 1'b0;
                    end else begin
                        pulseCnt_reg <= pulseCnt_reg + 16'h0001;
                    end
                end
                SIPC_TX_GAP: begin
                    txOut_reg   <= 1'b0;
                    txState_reg <= SIPC_TX_IDLE;
                end
                default: begin
                    txState_reg <= SIPC_TX_IDLE;
                end
            endcase
        end
    end

    assign txPin = txOut_reg;

    // Receive path: source select, filter, then demodulation
    logic rxSource;
    logic rxFiltered;
    logic [6:0] rxFiltLen;
    logic rxOut_reg;

    assign rxSource  = eventEn_reg ? (runEn & evSync_reg[1]) : rxSync_reg[1];
    assign rxFiltLen = irMode_reg ? rxFilterLen_reg : 7'h00;

    sipc_rx_filter #(
        .LEN_WIDTH(`SIPC_RX_FILTER_WIDTH)
    ) u_rx_filter (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .runEn    (runEn),
        .filterLen(rxFiltLen),
        .rawIn    (rxSource),
        .filtOut  (rxFiltered)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rxOut_reg <= 1'b1;
        end else if (runEn) begin
            rxOut_reg <= (txBypass) ? rxFiltered : ~rxFiltered;
        end
    end

    assign rxData = rxOut_reg;

    // AXI4-Lite read path
    logic        rValid_reg;
    logic [31:0] rData_reg;
    logic [1:0]  rResp_reg;
    logic [ADDR_WIDTH-3:0] rdIdx;
    logic [31:0] rdWord;
    logic        rdHit;

    assign s_axi_arready = ~rValid_reg;
    assign rdIdx = s_axi_araddr[ADDR_WIDTH-1:2];

    always_comb begin
        rdHit  = 1'b1;
        if (rdIdx == `SIPC_IDX_BAUD_LOW) begin
            rdWord = {24'h000000, baudDiv_reg[7:0]};
        end else if (rdIdx == `SIPC_IDX_BAUD_HIGH) begin
            rdWord = {24'h000000, baudDiv_reg[15:8]};
        end else if (rdIdx == `SIPC_IDX_MODE) begin
            rdWord = {31'h00000000, irMode_reg};
        end else if (rdIdx == `SIPC_IDX_DEBUG_RUN) begin
            rdWord = {31'h00000000, runHalted_reg};
        end else if (rdIdx == `SIPC_IDX_EVENT_CTRL) begin
            rdWord = {31'h00000000, eventEn_reg};
        end else if (rdIdx == `SIPC_IDX_TX_PULSE) begin
            rdWord = {24'h000000, txPulseLen_reg};
        end else if (rdIdx == `SIPC_IDX_RX_FILTER) begin
            rdWord = {25'h0000000, rxFilterLen_reg};
        end else if (rdIdx == `SIPC_IDX_STATUS) begin
            rdWord = {28'h0000000, txState_reg, rxOut_reg, runEn};
        end else begin
            rdWord = 32'h00000000;
            rdHit  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rValid_reg <= 1'b0;
            rData_reg  <= 32'h00000000;
            rResp_reg  <= SIPC_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_reg <= 1'b1;
            rData_reg  <= rdWord;
            rResp_reg  <= rdHit ? SIPC_OKAY : SIPC_SLVERR;
        end else if (s_axi_rready) begin
            rValid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata  = rData_reg;
    assign s_axi_rresp  = rResp_reg;

    // Checks
    property p_halt_freeze;
        @(posedge clk_sys) disable iff (rst)
        (!runEn && !$past(rst)) |=> $stable(baudCnt_reg);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("ran while halted");

    property p_run_halted;
        @(posedge clk_sys) disable iff (rst)
        (runHalted_reg) |-> runEn;
    endproperty
    a_run_halted: assert property (p_run_halted) else $error("stopped with debug run");

    property p_event_src;
        @(posedge clk_sys) disable iff (rst)
        (eventEn_reg && runEn) |-> (rxSource == evSync_reg[1]);
    endproperty
    a_event_src: assert property (p_event_src) else $error("event not selected");

    property p_pin_ignored;
        @(posedge clk_sys) disable iff (rst)
        (eventEn_reg && !runEn) |-> (rxSource == 1'b0);
    endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("rx pin used");

    property p_non_ir;
        @(posedge clk_sys) disable iff (rst)
        (!irMode_reg && runEn) |=> (txPin == $past(txData));
    endproperty
    a_non_ir: assert property (p_non_ir) else $error("coding outside ir mode");

    property p_pulse_start;
        @(posedge clk_sys) disable iff (rst)
        ($rose(txPin) && !txBypass && $past(!txBypass)) |-> $past(baudTick_reg);
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse not on baud");

    property p_fixed_len;
        @(posedge clk_sys) disable iff (rst)
        (txState_reg == SIPC_TX_PULSE && pulseCnt_reg >= pulseLen && runEn && !txBypass)
            |=> (!txPin && txState_reg == SIPC_TX_GAP);
    endproperty
    a_fixed_len: assert property (p_fixed_len) else $error("pulse length wrong");

    property p_len_316;
        @(posedge clk_sys) disable iff (rst)
        (txPulseLen_reg == 8'h00) |-> (pulseLen == 16'(3) * (baudDiv_reg + 16'h0001));
    endproperty
    a_len_316: assert property (p_len_316) else $error("3/16 length wrong");

    property p_bypass;
        @(posedge clk_sys) disable iff (rst)
        (txPulseLen_reg == 8'hFF && runEn) |=> (txPin == $past(txData));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass altered tx");

    property p_rx_nofilter;
        @(posedge clk_sys) disable iff (rst)
        (rxFiltLen == 7'h00 && runEn) |=> (rxFiltered == $past(rxSource));
    endproperty
    a_rx_nofilter: assert property (p_rx_nofilter) else $error("filter not bypassed");
endmodule

// >>> design/sipc_rx_filter.sv
// Receive pulse filter: accepts a level after x+1 consecutive equal samples
`timescale 1ns/10ps
`include "sipc_map.svh"
module sipc_rx_filter
    import sipc_pkg::*;
#(
    parameter int LEN_WIDTH = `SIPC_RX_FILTER_WIDTH
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 runEn,
    input  wire logic [LEN_WIDTH-1:0] filterLen,
    input  wire logic                 rawIn,
    output logic                      filtOut
);
    initial begin
        if (LEN_WIDTH < 1 || LEN_WIDTH > 16) begin
            $error("sipc_rx_filter: LEN_WIDTH out of range");
        end
    end

    logic                 prev_reg;
    logic [LEN_WIDTH-1:0] count_reg;
    logic                 out_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_reg  <= 1'b1;
            count_reg <= '0;
        end else if (runEn) begin
            prev_reg <= rawIn;
            if (rawIn != prev_reg) begin
                count_reg <= '0;
            end else if (count_reg != filterLen) begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_reg <= 1'b1;
        end else if (runEn) begin
            if (filterLen == '0) begin
                out_reg <= rawIn;
            end else if (rawIn == prev_reg && count_reg + 1'b1 == filterLen) begin
                out_reg <= rawIn;
            end
        end
    end

    assign filtOut = out_reg;

    property p_filter_run;
        @(posedge clk_sys) disable iff (rst)
        (runEn && filterLen != '0 && $changed(out_reg)) |->
            (count_reg == '0 || $past(count_reg) + 1'b1 == filterLen);
    endproperty
    a_filter_run: assert property (p_filter_run) else $error("filter accepted early");
endmodule

// >>> shared/sipc_map.svh
// Register map, field positions, reset values and timing constants of the infrared codec
`ifndef SIPC_MAP_SVH
`define SIPC_MAP_SVH

`define SIPC_IDX_BAUD_LOW       8'h08
`define SIPC_IDX_BAUD_HIGH      8'h09
`define SIPC_IDX_MODE           8'h0A
`define SIPC_IDX_DEBUG_RUN      8'h0B
`define SIPC_IDX_EVENT_CTRL     8'h0C
`define SIPC_IDX_TX_PULSE       8'h0D
`define SIPC_IDX_RX_FILTER      8'h0E
`define SIPC_IDX_STATUS         8'h0F

`define SIPC_BIT_RUN_HALTED     0
`define SIPC_BIT_EVENT_ENABLE   0
`define SIPC_BIT_IR_MODE        0
`define SIPC_RX_FILTER_WIDTH    7

`define SIPC_RST_BAUD           16'h0000
`define SIPC_RST_BYTE           8'h00

`define SIPC_TX_PULSE_316       8'h00
`define SIPC_TX_PULSE_BYPASS    8'hFF
`define SIPC_OVERSAMPLE         16
`define SIPC_PULSE_SIXTEENTHS   3

`endif

// >>> shared/sipc_pkg.sv
// Types shared by the infrared codec design
package sipc_pkg;
    typedef enum logic [1:0] {
        SIPC_TX_IDLE  = 2'b00,
        SIPC_TX_PULSE = 2'b01,
        SIPC_TX_GAP   = 2'b10
    } sipc_tx_state_t;

    typedef logic [1:0] sipc_resp_t;
    localparam sipc_resp_t SIPC_OKAY   = 2'b00;
    localparam sipc_resp_t SIPC_SLVERR = 2'b10;
endpackage

// >>> verification/sipc_codec_test.sv
// Self-checking bench for the infrared codec
`timescale 1ns/10ps
module sipc_codec_test
    import sipc_pkg::*;
;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdat;
        logic [31:0] rdat;
        logic [1:0]  resp;
    } sipc_row_t;
    sipc_row_t rows [7] = '{
        '{8'h20, 32'hA5, 32'hA5, SIPC_OKAY},
        '{8'h24, 32'h3C, 32'h3C, SIPC_OKAY},
        '{8'h2C, 32'h01, 32'h01, SIPC_OKAY},
        '{8'h30, 32'h01, 32'h01, SIPC_OKAY},
        '{8'h34, 32'hFE, 32'hFE, SIPC_OKAY},
        '{8'h38, 32'hFF, 32'h7F, SIPC_OKAY},
        '{8'h40, 32'h05, 32'h00, SIPC_SLVERR}};
    logic        clk_sys = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  awAddr = 8'h00;
    logic [7:0]  arAddr = 8'h00;
    logic [31:0] wData = 32'h0;
    logic [31:0] rData;
    logic        awValid = 1'h0;
    logic        wValid = 1'h0;
    logic        arValid = 1'h0;
    logic        awReady, wReady, bValid, arReady, rValid;
    logic [1:0]  bResp, rResp;
    logic        cpuHalted = 1'h0;
    logic        txData = 1'h1;
    logic        rxData, rxPin, eventIn, txPin, baudTick;
    logic [7:0]  txWidth;
    logic [31:0] ticks = 32'h0;
    logic        rxLow = 1'h0;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;

    sipc_codec sipc_codec_i (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'h1),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(1'h1), .cpuHalted(cpuHalted), .txData(txData), .rxData(rxData),
        .rxPin(rxPin), .eventIn(eventIn), .txPin(txPin), .baudTick(baudTick));
    sipc_ir_partner sipc_ir_partner_i (.clk_sys(clk_sys), .txPin(txPin), .rxPin(rxPin),
        .eventIn(eventIn), .txWidth(txWidth));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (baudTick === 1'h1)
            ticks <= ticks + 32'h1;
        if (rxData === 1'h0)
            rxLow <= 1'h1;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out();
        if (n_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Address and data offered together; each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah;
        logic wh;
        logic ad;
        logic wd;
        ad = 1'h0;
        wd = 1'h0;
        awAddr <= a;
        wData <= d;
        awValid <= 1'h1;
        wValid <= 1'h1;
        // Track what was taken locally: the valid variables only change after the edge
        while (!(ad && wd)) begin
            @(negedge clk_sys);
            ah = awReady;
            wh = wReady;
            @(posedge clk_sys);
            if (ah === 1'h1 && !ad) begin
                awValid <= 1'h0;
                ad = 1'h1;
            end
            if (wh === 1'h1 && !wd) begin
                wValid <= 1'h0;
                wd = 1'h1;
            end
        end
        do @(negedge clk_sys); while (bValid !== 1'h1);
        r = bResp;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        arAddr <= a;
        arValid <= 1'h1;
        do @(negedge clk_sys); while (arReady !== 1'h1);
        @(posedge clk_sys);
        arValid <= 1'h0;
        do @(negedge clk_sys); while (rValid !== 1'h1);
        d = rData;
        r = rResp;
        @(posedge clk_sys);
    endtask
    task automatic set(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] s;
        wr(a, d, s);
        chk({30'h0, s}, {30'h0, SIPC_OKAY});
    endtask
    task automatic tickCount(input logic [31:0] exp);
        logic [31:0] t0;
        repeat (40) @(posedge clk_sys);
        t0 = ticks;
        repeat (64) @(posedge clk_sys);
        chk(ticks - t0, exp);
    endtask
    task automatic rxTry(input logic ev, input logic [7:0] pat, input logic exp);
        @(posedge clk_sys);
        rxLow <= 1'h0;
        sipc_ir_partner_i.send(ev, pat);
        repeat (12) @(posedge clk_sys);
        chk({31'h0, rxLow}, {31'h0, exp});
    endtask

    initial begin
        sipc_row_t r;
        logic [31:0] d;
        logic [1:0] s;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            r = rows[i];
            rd(r.addr, d, s);
            chk(d, 32'h0);
            wr(r.addr, r.wdat, s);
            chk({30'h0, s}, {30'h0, r.resp});
            rd(r.addr, d, s);
            chk(d, r.rdat);
            chk({30'h0, s}, {30'h0, r.resp});
        end
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        rd(8'h24, d, s);
        chk(d, 32'h0);
        tickCount(32'h4);
        set(8'h20, 32'h1);
        tickCount(32'h2);
        set(8'h20, 32'h0);
        cpuHalted <= 1'h1;
        tickCount(32'h0);
        set(8'h2C, 32'h1);
        tickCount(32'h4);
        set(8'h34, 32'h5);
        set(8'h28, 32'h1);
        txData <= 1'h0;
        repeat (40) @(posedge clk_sys);
        chk({24'h0, txWidth}, 32'h5);
        set(8'h34, 32'h0);
        repeat (40) @(posedge clk_sys);
        chk({24'h0, txWidth}, 32'h3);
        set(8'h34, 32'hFF);
        txData <= 1'h1;
        repeat (4) @(posedge clk_sys);
        chk({31'h0, txPin}, 32'h1);
        txData <= 1'h0;
        repeat (4) @(posedge clk_sys);
        chk({31'h0, txPin}, 32'h0);
        set(8'h34, 32'h5);
        set(8'h28, 32'h0);
        repeat (4) @(posedge clk_sys);
        chk({31'h0, txPin}, 32'h0);
        chk({31'h0, rxData}, 32'h0);
        txData <= 1'h1;
        set(8'h38, 32'h3);
        set(8'h28, 32'h1);
        repeat (8) @(posedge clk_sys);
        rxTry(1'h0, 8'hE0, 1'h0);
        rxTry(1'h0, 8'hF0, 1'h1);
        rxTry(1'h0, 8'hD8, 1'h0);
        set(8'h38, 32'h0);
        rxTry(1'h0, 8'h80, 1'h1);
        set(8'h30, 32'h1);
        rxTry(1'h0, 8'hF0, 1'h0);
        rxTry(1'h1, 8'h80, 1'h1);
        set(8'h2C, 32'h0);
        rxTry(1'h1, 8'hF0, 1'h0);
        close_out();
    end
endmodule

// >>> verification/sipc_ir_partner.sv
// Infrared transceiver model: sends receive patterns, measures transmit pulses
`timescale 1ns/10ps
module sipc_ir_partner (
    input  wire logic clk_sys,
    input  wire logic txPin,
    output logic      rxPin,
    output logic      eventIn,
    output logic [7:0] txWidth
);
    logic [7:0] runLen = 8'h00;
    initial begin
        rxPin = 1'h0;
        eventIn = 1'h0;
        txWidth = 8'h00;
    end
    // Width of the last completed high pulse on the transmit line
    always @(posedge clk_sys) begin
        runLen <= txPin ? runLen + 8'h01 : 8'h00;
        if (!txPin && runLen != 8'h00)
            txWidth <= runLen;
    end
    // Pattern leaves MSB first, one bit a clock; the line then idles low
    task automatic send(input logic useEvent, input logic [7:0] pat);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_sys);
            if (useEvent)
                eventIn <= pat[i];
            else
                rxPin <= pat[i];
        end
        @(posedge clk_sys);
        rxPin <= 1'h0;
        eventIn <= 1'h0;
    endtask
endmodule
